// File: common/adc_seq_defs.svh
// adc_seq_defs.svh: register offsets, reset values, codes, timing counts
// assumes: included by bare name from the sequencer sources
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// apb word offsets
`define OFS_CTRL          8'h00
`define OFS_MASK          8'h04
`define OFS_STATUS        8'h08

// widths and reset values
`define CTRL_W            12
`define MASK_W            8
`define STAT_W            10
`define CTRL_RST          12'h000
`define MASK_RST          8'h00
`define CH_FIRST          3'h0
`define CH_LAST           3'h7
`define CH_PAIR_BIT       3'h1

// {sequence_select, channel_mask_select}
`define SEQ_DIRECT        2'h0
`define SEQ_MASK          2'h1
`define SEQ_CONTINUE      2'h2
`define SEQ_CONSEC        2'h3

// {input_config_bit1, input_config_bit0}
`define CFG_SINGLE        2'h0
`define CFG_PSEUDO4       2'h1
`define CFG_DIFF          2'h2
`define CFG_PSEUDO7       2'h3

// conversion timing
`define CLK_PERIOD_NS     10
`define CONVCLK_PERIOD_NS 100
`define CONV_DIV          ((`CONVCLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TICKS        14

`endif

// File: common/adc_seq_pkg.sv
// adc_seq_pkg: types shared by the channel sequencer files
// assumes: field positions match the control word on the apb bus
package adc_seq_pkg;

    typedef struct packed {
        logic [4:0] spare;
        logic       internal_ref_select;
        logic       sequence_select;
        logic       channel_mask_select;
        logic       input_config_bit1;
        logic       input_config_bit0;
        logic [2:0] channel_address;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] pos;
        logic [2:0] neg;
        logic       neg_agnd;
    } mux_sel_t;

    typedef enum logic [1:0] {
        RUN_DIRECT,
        RUN_MASK,
        RUN_CONSEC
    } run_mode_t;

    typedef struct packed {
        logic [2:0] conv_ch;
        logic [2:0] next_ch;
        logic [1:0] run_mode;
        logic       ref_int;
        logic       busy;
    } status_t;

endpackage : adc_seq_pkg

// File: verilog/pin_sync_fall.sv
// pin_sync_fall: two-flop synchroniser with falling edge pulse
// assumes: pin idles high and is asynchronous to i_clk
`timescale 1ns/1ns
`default_nettype none

module pin_sync_fall (
    input  wire logic i_clk,   // system clock
    input  wire logic i_rst,   // async reset, active high
    input  wire logic i_pin,   // raw pin
    output logic      o_fall   // one-cycle pulse on falling edge
);
    logic meta;
    logic sync;
    logic last;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta   <= 1'b1;
            sync   <= 1'b1;
            last   <= 1'b1;
            o_fall <= 1'b0;
        end else begin
            meta   <= i_pin;
            sync   <= meta;
            last   <= sync;
            o_fall <= last & ~sync;
        end
    end
endmodule : pin_sync_fall

`default_nettype wire

// File: verilog/conv_timer.sv
// conv_timer: conversion clock enable and busy window
// assumes: start is a one-cycle pulse from the same clock
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.svh"

module conv_timer (
    input  wire logic i_clk,   // system clock
    input  wire logic i_rst,   // async reset, active high
    input  wire logic i_start, // start pulse, ignored while busy
    output logic      o_busy,  // high for the whole conversion
    output logic      o_done   // one-cycle pulse as busy falls
);
    logic [7:0] div;
    logic [4:0] ticks;
    wire        tick_en  = (div == 8'(`CONV_DIV - 1));
    wire        last_tick = (ticks == 5'(`CONV_TICKS - 1));

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            div    <= 8'h00;
            ticks  <= 5'h00;
        end else begin
            o_done <= o_busy & tick_en & last_tick;
            if (i_start && !o_busy) begin
                o_busy <= 1'b1;
                div    <= 8'h00;
                ticks  <= 5'h00;
            end else if (o_busy && tick_en) begin
                div    <= 8'h00;
                ticks  <= ticks + 5'h01;
                o_busy <= ~last_tick;
            end else if (o_busy) begin
                div    <= div + 8'h01;
            end
        end
    end
endmodule : conv_timer

`default_nettype wire

// File: verilog/adc_channel_sequencer.sv
// adc_channel_sequencer: channel selection and sequencing for an
// eight-input converter, control and mask registers on apb
// assumes: apb master on i_clk, convert_start_n asynchronous pin
//
// Function
// - config 0,1 four pseudo pairs; 1,1 seven
// - direct mode converts written channel_address
// - mask mode converts only mask-enabled channels, channel 0 while the mask is zero
// - mask mode starts at lowest enabled channel
// - mask mode steps to next higher enabled
// - after highest enabled, wrap to lowest
// - write with 1,0 continues running sequence; one landing on conversion end repeats that channel
// - program holds until non 1,0 write
// - consecutive mode runs channel 0 to address
// - consecutive mode first conversion is channel 0
// - after final channel restart at channel 0
// - reference select bit picks internal or external
// - config 0,0 eight single-ended, negative grounded
// - config bit1 alone gives four differential pairs
// - convert_start_n fall starts; busy during conversion
// - control captured on completed write strobe
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.svh"

module adc_channel_sequencer (
    input  wire logic                 i_clk,             // 100 MHz clock
    input  wire logic                 i_rst,             // async, high
    input  wire logic                 i_psel,            // apb select
    input  wire logic                 i_penable,         // apb enable
    input  wire logic                 i_pwrite,          // apb direction
    input  wire logic [7:0]           i_paddr,           // apb address
    input  wire logic [31:0]          i_pwdata,          // apb write data
    output logic      [31:0]          o_prdata,          // apb read data
    output logic                      o_pready,          // apb ready
    output logic                      o_pslverr,         // unmapped
    input  wire logic                 i_convert_start_n, // start pin
    output logic                      o_busy,            // converting
    output adc_seq_pkg::mux_sel_t     o_mux,             // mux select
    output logic                      o_ref_internal,    // internal ref
    output logic      [2:0]           o_channel_id       // converted ch
);
    localparam int BUSY_CYC = `CONV_DIV * `CONV_TICKS;

    adc_seq_pkg::ctrl_t     ctrl;
    logic [7:0]             shadow_mask;
    adc_seq_pkg::run_mode_t run_mode;
    adc_seq_pkg::run_mode_t next_run_mode;
    logic [2:0]             cur_ch;
    logic [2:0]             next_cur_ch;
    logic [2:0]             final_ch;
    logic [2:0]             next_final_ch;
    logic [2:0]             conv_ch;
    logic                   fresh;
    logic                   next_fresh;
    logic                   start_fall;
    logic                   conv_done;
    logic                   busy;

    // lowest set bit at or above from (above when !incl), else wrap
    function automatic logic [2:0] pick_next(
        input logic [7:0] m,
        input logic [2:0] from,
        input logic       incl
    );
        logic [2:0] res;
        logic [3:0] base;
        res  = from;
        base = incl ? {1'b0, from} : ({1'b0, from} + 4'h1);
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                res = 3'(i);
            end
        end
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && (4'(i) >= base)) begin
                res = 3'(i);
            end
        end
        return res;
    endfunction : pick_next

    // multiplexer routing for one channel under the input config
    function automatic adc_seq_pkg::mux_sel_t route(
        input logic [1:0] cfg,
        input logic [2:0] ch
    );
        adc_seq_pkg::mux_sel_t r;
        r.pos      = ch;
        r.neg      = ch;
        r.neg_agnd = 1'b1;
        case (cfg)
            `CFG_SINGLE: begin
                r.neg_agnd = 1'b1;
            end
            `CFG_DIFF: begin
                r.neg      = ch ^ `CH_PAIR_BIT;
                r.neg_agnd = 1'b0;
            end
            `CFG_PSEUDO4: begin
                r.pos      = ch & ~`CH_PAIR_BIT;
                r.neg      = ch | `CH_PAIR_BIT;
                r.neg_agnd = 1'b0;
            end
            `CFG_PSEUDO7: begin
                r.neg      = `CH_LAST;
                r.neg_agnd = 1'b0;
            end
            default: begin
                r.neg_agnd = 1'b1;
            end
        endcase
        return r;
    endfunction : route

    // apb decode: write lands on the edge that sees pready high
    wire        apb_setup  = i_psel & i_penable & ~o_pready;
    wire        apb_fire   = i_psel & i_penable & o_pready;
    wire        sel_ctrl   = (i_paddr == `OFS_CTRL);
    wire        sel_mask   = (i_paddr == `OFS_MASK);
    wire        sel_status = (i_paddr == `OFS_STATUS);
    wire        mapped     = sel_ctrl | sel_mask | sel_status;
    wire        ctrl_wr    = apb_fire & i_pwrite & sel_ctrl;
    wire        mask_wr    = apb_fire & i_pwrite & sel_mask;
    wire adc_seq_pkg::ctrl_t ctrl_in = i_pwdata[`CTRL_W-1:0];
    wire [7:0]  mask_in    = i_pwdata[`MASK_W-1:0];
    wire [1:0]  seq_pair   = {ctrl_in.sequence_select,
                              ctrl_in.channel_mask_select};
    wire        keep_run   = (seq_pair == `SEQ_CONTINUE);
    wire [1:0]  cfg        = {ctrl.input_config_bit1,
                              ctrl.input_config_bit0};
    wire        start_ok   = start_fall & ~busy;
    wire [2:0]  route_ch   = busy ? conv_ch : cur_ch;
    wire [7:0]  mask_above = shadow_mask >> conv_ch;
    wire        any_above  = |mask_above[7:1];
    wire        advance    = conv_done & ~fresh & ~ctrl_wr & ~mask_wr;

    wire adc_seq_pkg::status_t status = '{
        conv_ch:  conv_ch,
        next_ch:  cur_ch,
        run_mode: run_mode,
        ref_int:  ctrl.internal_ref_select,
        busy:     busy
    };

    pin_sync_fall u_start_sync (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_pin  (i_convert_start_n),
        .o_fall (start_fall)
    );

    conv_timer u_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_start (start_ok),
        .o_busy  (busy),
        .o_done  (conv_done)
    );

    // sequencing program and channel pointer
    always_comb begin
        next_run_mode = run_mode;
        next_cur_ch   = cur_ch;
        next_final_ch = final_ch;
        next_fresh    = start_ok ? 1'b0 : fresh;
        if (ctrl_wr && !keep_run) begin
            next_fresh = 1'b1;
            case (seq_pair)
                `SEQ_DIRECT: begin
                    next_run_mode = adc_seq_pkg::RUN_DIRECT;
                    next_cur_ch   = ctrl_in.channel_address;
                end
                `SEQ_MASK: begin
                    next_run_mode = adc_seq_pkg::RUN_MASK;
                    next_cur_ch   = pick_next(shadow_mask, `CH_FIRST,
                                              1'b1);
                end
                default: begin
                    next_run_mode = adc_seq_pkg::RUN_CONSEC;
                    next_cur_ch   = `CH_FIRST;
                    next_final_ch = ctrl_in.channel_address;
                end
            endcase
        end else if (mask_wr && run_mode == adc_seq_pkg::RUN_MASK) begin
            next_fresh  = 1'b1;
            next_cur_ch = pick_next(mask_in, `CH_FIRST, 1'b1);
        end else if (advance) begin
            case (run_mode)
                adc_seq_pkg::RUN_MASK: begin
                    next_cur_ch = pick_next(shadow_mask, conv_ch,
                                            1'b0);
                end
                adc_seq_pkg::RUN_CONSEC: begin
                    next_cur_ch = (conv_ch == final_ch) ? `CH_FIRST
                                : conv_ch + 3'h1;
                end
                default: begin
                    next_cur_ch = cur_ch;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_mode <= adc_seq_pkg::RUN_DIRECT;
            cur_ch   <= `CH_FIRST;
            final_ch <= `CH_FIRST;
            fresh    <= 1'b1;
        end else begin
            run_mode <= next_run_mode;
            cur_ch   <= next_cur_ch;
            final_ch <= next_final_ch;
            fresh    <= next_fresh;
        end
    end

    // control and mask registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl        <= `CTRL_RST;
            shadow_mask <= `MASK_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl <= ctrl_in;
            end
            if (mask_wr) begin
                shadow_mask <= mask_in;
            end
        end
    end

    // channel fixed at the start of each conversion
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            conv_ch      <= `CH_FIRST;
            o_channel_id <= `CH_FIRST;
        end else if (start_ok) begin
            conv_ch      <= cur_ch;
            o_channel_id <= cur_ch;
        end
    end

    // analog side controls
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mux          <= '{pos: `CH_FIRST, neg: `CH_FIRST, neg_agnd: 1'b1};
            o_ref_internal <= 1'b0;
            o_busy         <= 1'b0;
        end else begin
            o_mux          <= route(cfg, route_ch);
            o_ref_internal <= ctrl.internal_ref_select;
            o_busy         <= busy;
        end
    end

    // apb answer: one wait state, error on unmapped addresses
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= apb_setup;
            o_pslverr <= apb_setup & ~mapped;
            if (apb_setup && !i_pwrite) begin
                o_prdata <= sel_ctrl   ? 32'(ctrl)
                          : sel_mask   ? 32'(shadow_mask)
                          : sel_status ? 32'(status)
                          : 32'h0000_0000;
            end else if (apb_setup) begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    // helper counter for busy length
    logic [15:0] busy_cnt;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= o_busy ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    AST_BUSY_LEN: assert property (
        $fell(o_busy) |-> busy_cnt == 16'(BUSY_CYC))
        else $error("busy window length wrong");

    AST_START_BUSY: assert property (
        start_ok |=> ##1 o_busy)
        else $error("busy not raised after start");

    AST_CH_FIXED: assert property (
        (busy && $past(busy)) |-> $stable(conv_ch))
        else $error("channel changed during conversion");

    AST_DIRECT_ADDR: assert property (
        (ctrl_wr && seq_pair == `SEQ_DIRECT)
        |=> cur_ch == $past(i_pwdata[2:0]))
        else $error("direct channel not taken");

    AST_MASK_ENABLED: assert property (
        (run_mode == adc_seq_pkg::RUN_MASK && shadow_mask != 8'h00)
        |-> shadow_mask[cur_ch])
        else $error("pointer on masked-off channel");

    AST_MASK_UP: assert property (
        (advance && run_mode == adc_seq_pkg::RUN_MASK && any_above)
        |=> cur_ch > $past(conv_ch))
        else $error("mask sequence did not step up");

    AST_MASK_WRAP: assert property (
        (advance && run_mode == adc_seq_pkg::RUN_MASK && !any_above)
        |=> cur_ch <= $past(conv_ch))
        else $error("mask sequence did not wrap");

    AST_CONSEC_FIRST: assert property (
        (ctrl_wr && seq_pair == `SEQ_CONSEC) |=> cur_ch == `CH_FIRST)
        else $error("consecutive run not at channel 0");

    AST_CONSEC_WRAP: assert property (
        (advance && run_mode == adc_seq_pkg::RUN_CONSEC
         && conv_ch == final_ch) |=> cur_ch == `CH_FIRST)
        else $error("consecutive run did not restart");

    AST_KEEP_RUN: assert property (
        (ctrl_wr && keep_run)
        |=> $stable(run_mode) && $stable(final_ch))
        else $error("continue write disturbed sequence");

    AST_REF_SEL: assert property (
        ctrl_wr |=> ##1 o_ref_internal == $past(i_pwdata[7], 2))
        else $error("reference select not applied");

endmodule : adc_channel_sequencer

`default_nettype wire

// File: testbench/conv_start_host.sv
// conv_start_host: host-side driver of the convert start pin
// assumes: bench clock on i_clk, converter busy level on i_busy
`timescale 1ns/1ns
`default_nettype none

module conv_start_host (
    input  wire logic i_clk,             // bench clock
    input  wire logic i_busy,            // converter busy
    output logic      o_convert_start_n  // start pin, idles high
);
    initial o_convert_start_n = 1'b1;

    // fall after some idle cycles, rise again once busy is seen
    task automatic start(input int idle, output logic ok);
        int i;
        ok = 1'b0;
        repeat (idle) @(posedge i_clk);
        @(posedge i_clk);
        o_convert_start_n <= 1'b0;
        for (i = 0; i < 20 && !ok; i++) begin
            @(posedge i_clk);
            ok = (i_busy === 1'b1);
        end
        o_convert_start_n <= 1'b1;
    endtask : start

    // next fall only after busy has dropped
    task automatic finish(output int n, output logic ok);
        ok = 1'b0;
        for (n = 0; n < 200 && !ok; ) begin
            @(posedge i_clk);
            n++;
            ok = (i_busy === 1'b0);
        end
    endtask : finish
endmodule : conv_start_host
`default_nettype wire

// File: testbench/test_adc_channel_sequencer.sv
// test_adc_channel_sequencer: apb and start pin bench for the sequencer
// assumes: host model drives the start pin, bench is the apb master
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.svh"

module test_adc_channel_sequencer;
    logic                  i_clk, i_rst, psel, penable, pwrite;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, d, q;
    logic                  pready, pslverr, start_n, busy, ref_int;
    logic [2:0]            chan;
    adc_seq_pkg::mux_sel_t mux;
    int                    miscompares, n_checks, k;

    adc_channel_sequencer u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_convert_start_n(start_n), .o_busy(busy), .o_mux(mux),
        .o_ref_internal(ref_int), .o_channel_id(chan));

    conv_start_host u_host (
        .i_clk(i_clk), .i_busy(busy), .o_convert_start_n(start_n));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    task automatic stall;
        miscompares++;
        $display("ERROR %0t wait ran out", $time);
        close_out();
    endtask : stall

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t word got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_ch(input logic [2:0] got, input logic [2:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t channel got %0d exp %0d", $time, got, exp);
        end
    endtask : chk_ch

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t flag got %b exp %b", $time, got, exp);
        end
    endtask : chk_bit

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic exp_err,
                       output logic [31:0] rd);
        int i;
        @(posedge i_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge i_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) stall();
        rd = prdata;
        chk_bit(pslverr, exp_err);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] mk(input logic [1:0] seq,
        input logic [1:0] cfg, input logic rf, input logic [2:0] ch);
        adc_seq_pkg::ctrl_t c;
        c = '0;
        c.sequence_select     = seq[1];
        c.channel_mask_select = seq[0];
        c.input_config_bit1   = cfg[1];
        c.input_config_bit0   = cfg[0];
        c.internal_ref_select = rf;
        c.channel_address     = ch;
        return 32'(c);
    endfunction : mk

    function automatic adc_seq_pkg::mux_sel_t exp_mux(input logic [1:0] cfg,
                                                    input logic [2:0] ch);
        exp_mux.pos      = ch;
        exp_mux.neg      = 3'h0;
        exp_mux.neg_agnd = (cfg == `CFG_SINGLE);
        case (cfg)
            `CFG_DIFF: exp_mux.neg = ch ^ `CH_PAIR_BIT;
            `CFG_PSEUDO4: begin
                exp_mux.pos = ch & ~`CH_PAIR_BIT;
                exp_mux.neg = ch | `CH_PAIR_BIT;
            end
            `CFG_PSEUDO7: exp_mux.neg = `CH_LAST;
            default: ;
        endcase
    endfunction : exp_mux

    // one conversion: channel, routing, reference and busy length
    task automatic conv_chk(input logic [2:0] ch, input logic [1:0] cfg,
                            input logic rf, input int idle);
        adc_seq_pkg::mux_sel_t e;
        logic                  ok;
        int                    n;
        e = exp_mux(cfg, ch);
        u_host.start(idle, ok);
        if (!ok) stall();
        chk_ch(chan, ch);
        chk_ch(mux.pos, e.pos);
        chk_bit(mux.neg_agnd, e.neg_agnd);
        if (cfg != `CFG_SINGLE) chk_ch(mux.neg, e.neg);
        chk_bit(ref_int, rf);
        u_host.finish(n, ok);
        if (!ok) stall();
        chk_word(32'(n), `CONV_DIV * `CONV_TICKS);
    endtask : conv_chk

    task automatic seq_chk(input logic [23:0] chs, input int n,
                           input logic [1:0] cfg, input logic rf);
        int i;
        for (i = 0; i < n; i++) begin
            conv_chk(chs[3*i +: 3], cfg, rf, (i % 2) * 9);
        end
    endtask : seq_chk

    initial begin
        miscompares = 0;
        n_checks    = 0;
        i_rst       = 1'b1;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0000_0000;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        chk_bit(busy, 1'b0);
        chk_bit(mux.neg_agnd, 1'b1);
        apb(1'b0, `OFS_CTRL, 32'h0000_0000, 1'b0, d);
        chk_word(d, 32'(`CTRL_RST));
        apb(1'b0, `OFS_MASK, 32'h0000_0000, 1'b0, d);
        chk_word(d, 32'(`MASK_RST));
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF, 1'b1, d);
        apb(1'b0, 8'h0C, 32'h0000_0000, 1'b1, d);
        chk_word(d, 32'h0000_0000);
        // direct mode, every channel and every input configuration
        for (k = 0; k < 8; k++) begin
            d = mk(`SEQ_DIRECT, 2'(k), k[0], 3'(k * 3));
            apb(1'b1, `OFS_CTRL, d, 1'b0, q);
            apb(1'b0, `OFS_CTRL, 32'h0000_0000, 1'b0, q);
            chk_word(q, d);
            conv_chk(3'(k * 3), 2'(k), k[0], k % 3);
        end
        // mask of channels 2, 5, 7, sequence checked over channels 2 and 5
        apb(1'b1, `OFS_MASK, 32'h0000_00A4, 1'b0, d);
        apb(1'b1, `OFS_CTRL, mk(`SEQ_MASK, `CFG_SINGLE, 1'b1, 3'h0), 1'b0,
            d);
        seq_chk({3'd5, 3'd2}, 2, `CFG_SINGLE, 1'b1);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000, 1'b0, d);
        chk_word({30'h0, d[3:2]}, 32'h0000_0001);
        // new mask restarts at its lowest channel, continue write, ref flips
        apb(1'b1, `OFS_MASK, 32'h0000_0024, 1'b0, d);
        apb(1'b1, `OFS_CTRL, mk(`SEQ_CONTINUE, `CFG_SINGLE, 1'b0, 3'h3),
            1'b0, d);
        seq_chk({3'd2, 3'd5, 3'd2}, 3, `CFG_SINGLE, 1'b0);
        // consecutive run from channel 0 up to 2, then a restart
        apb(1'b1, `OFS_CTRL, mk(`SEQ_CONSEC, `CFG_SINGLE, 1'b1, 3'h2), 1'b0,
            d);
        seq_chk({3'd1, 3'd0, 3'd2, 3'd1, 3'd0}, 5, `CFG_SINGLE,
                1'b1);
        apb(1'b1, `OFS_CTRL, mk(`SEQ_CONTINUE, `CFG_SINGLE, 1'b1, 3'h6),
            1'b0, d);
        seq_chk({3'd0, 3'd2}, 2, `CFG_SINGLE, 1'b1);
        // leaving the program for direct mode, one write per conversion
        apb(1'b1, `OFS_CTRL, mk(`SEQ_DIRECT, `CFG_SINGLE, 1'b0, 3'h6), 1'b0,
            d);
        conv_chk(3'h6, `CFG_SINGLE, 1'b0, 0);
        apb(1'b1, `OFS_CTRL, mk(`SEQ_DIRECT, `CFG_SINGLE, 1'b0, 3'h4), 1'b0,
            d);
        conv_chk(3'h4, `CFG_SINGLE, 1'b0, 9);
        close_out();
    end
endmodule : test_adc_channel_sequencer
`default_nettype wire
